//--- shared/psave_consts.svh
`ifndef PSAVE_CONSTS_SVH
`define PSAVE_CONSTS_SVH
// Clock divider register field positions
`define CDIV_ROI_BIT      15
`define CDIV_RATIO_HI     14
`define CDIV_RATIO_LO     12
`define CDIV_SLOW_BIT     11
`define CDIV_RESET        16'h0000
// Peripheral slot count and layout, divider ratio and counter widths
`define NUM_MODS          8
`define MODS_NO_EN        8'b1110_0000
`define RATIO_W           3
`define DOZE_CNT_W        8
`endif

//--- shared/psave_pkg.sv
package psave_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_ENTER = 2'b01,
    ST_IDLE  = 2'b10
  } pmode_t;
endpackage

//--- src/doze_divider.sv
`timescale 1ns/1ps
`include "psave_consts.svh"
module doze_divider (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     doze_on,
  input  wire logic [`RATIO_W-1:0]      ratio,
  output logic                          cpu_en
);
  typedef struct packed {
    logic [`DOZE_CNT_W-1:0] cnt;
    logic                   en;
  } div_t;
  div_t s_r, s_nxt;

  // Power-of-two divisions; code 0 is 1:1, code 6 is 1:64... mapped so 7 gives 1:256
  function automatic logic [`DOZE_CNT_W-1:0] term_of(input logic [`RATIO_W-1:0] r);
    term_of = (r == 3'h7) ? 8'hFF : 8'((9'h001 << r) - 9'h001);
  endfunction

  always_comb begin
    s_nxt = s_r;
    if (!doze_on || ratio == 3'h0) begin
      s_nxt.cnt = 8'h00;
      s_nxt.en  = 1'b1;
    end else if (s_r.cnt >= term_of(ratio)) begin
      s_nxt.cnt = 8'h00;
      s_nxt.en  = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
      s_nxt.en  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{cnt: 8'h00, en: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign cpu_en = s_r.en;
endmodule // doze_divider

//--- src/module_gate.sv
`timescale 1ns/1ps
`include "psave_consts.svh"
module module_gate (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic [`NUM_MODS-1:0]  md_bits,
  input  wire logic [`NUM_MODS-1:0]  en_bits,
  input  wire logic [`NUM_MODS-1:0]  sidl_bits,
  input  wire logic                  in_idle,
  output logic      [`NUM_MODS-1:0]  clk_en,
  output logic      [`NUM_MODS-1:0]  run_en,
  output logic      [`NUM_MODS-1:0]  reg_access
);
  typedef struct packed {
    logic [`NUM_MODS-1:0] ck;
    logic [`NUM_MODS-1:0] run;
    logic [`NUM_MODS-1:0] acc;
  } gate_t;
  gate_t s_r, s_nxt;

  always_comb begin
    s_nxt.ck  = ~md_bits;
    s_nxt.acc = ~md_bits;
    // Slots without an enable bit ignore it
    s_nxt.run = ~md_bits & (en_bits | `MODS_NO_EN)
                & ~(sidl_bits & {`NUM_MODS{in_idle}});
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign clk_en     = s_r.ck;
  assign run_en     = s_r.run;
  assign reg_access = s_r.acc;
endmodule // module_gate

//--- src/power_save_clock_gating.sv
`timescale 1ns/1ps
`include "psave_consts.svh"
// Functional notes
// - Idle halts CPU until wake event
// - Entering Idle clears watchdog count
// - Idle keeps system clock, peripherals clocked
// - Idle keeps RC oscillator if watchdog/monitor
// - Wake on interrupt, reset, watchdog time-out
// - Wake restores CPU clock immediately
// - Interrupt during entry deferred until entry done
// - Doze slows only CPU, peripherals full
// - Bit 11 enables slow CPU
// - Bits 14:12 choose eight ratios, 1:1 default
// - Bit 15 makes interrupt end doze
// - Disable bit removes clock, blocks registers
// - Function enable stops module, registers stay
// - Capture, compare, clock lack enable bit
// - Stop-in-idle bit halts module in Idle
module power_save_clock_gating (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  power_save_instruction,
  input  wire logic                  irq_pending,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  watchdog_enable,
  input  wire logic                  fail_safe_monitor_enable,
  input  wire logic                  cdiv_we,
  input  wire logic [15:0]           cdiv_wdata,
  input  wire logic [`NUM_MODS-1:0]  module_clock_disable_bit,
  input  wire logic [`NUM_MODS-1:0]  module_function_enable_bit,
  input  wire logic [`NUM_MODS-1:0]  stop_in_idle_bit,
  output logic                       cpu_clk_en,
  output logic                       periph_clk_en,
  output logic                       sys_clk_run,
  output logic                       low_power_rc_oscillator_run,
  output logic                       watchdog_clear,
  output logic                       in_idle,
  output logic [15:0]                cdiv_rdata,
  output logic [`NUM_MODS-1:0]       mod_clk_en,
  output logic [`NUM_MODS-1:0]       mod_run_en,
  output logic [`NUM_MODS-1:0]       mod_reg_access
);
  // -----------------------------------------------------------
  // Two-flop sync of asynchronous wake sources
  // -----------------------------------------------------------
  logic [1:0] irq_sy, wdt_sy;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sy <= 2'b00;
      wdt_sy <= 2'b00;
    end else begin
      irq_sy <= {irq_sy[0], irq_pending};
      wdt_sy <= {wdt_sy[0], watchdog_timeout};
    end
  end
  wire logic irq_s = irq_sy[1];
  wire logic wdt_s = wdt_sy[1];

  // -----------------------------------------------------------
  // State
  // -----------------------------------------------------------
  typedef struct packed {
    psave_pkg::pmode_t mode;
    logic [15:0]       cdiv;
    logic              wclr;
    logic              cpu_en;
    logic              low_power_rc_oscillator;
    logic              idle;
  } ctl_t;
  ctl_t s_r, s_nxt;

  logic doze_tick;
  wire logic doze_on = s_r.cdiv[`CDIV_SLOW_BIT];
  wire logic [`RATIO_W-1:0] ratio =
    s_r.cdiv[`CDIV_RATIO_HI:`CDIV_RATIO_LO];

  always_comb begin
    s_nxt      = s_r;
    s_nxt.wclr = 1'b0;
    if (cdiv_we) begin
      s_nxt.cdiv = cdiv_wdata;
    end
    // Interrupt ends doze only when return-on-interrupt is set
    if (irq_s && s_r.cdiv[`CDIV_ROI_BIT]) begin
      s_nxt.cdiv[`CDIV_SLOW_BIT] = 1'b0;
    end
    case (s_r.mode)
      psave_pkg::ST_RUN: begin
        s_nxt.cpu_en = doze_tick;
        if (power_save_instruction) begin
          s_nxt.mode   = psave_pkg::ST_ENTER;
          s_nxt.cpu_en = 1'b0;
        end
      end
      psave_pkg::ST_ENTER: begin
        // Wake sources ignored here so entry always completes
        s_nxt.mode   = psave_pkg::ST_IDLE;
        s_nxt.idle   = 1'b1;
        s_nxt.wclr   = 1'b1;
        s_nxt.cpu_en = 1'b0;
      end
      psave_pkg::ST_IDLE: begin
        s_nxt.cpu_en = 1'b0;
        if (irq_s || wdt_s) begin
          s_nxt.mode   = psave_pkg::ST_RUN;
          s_nxt.idle   = 1'b0;
          s_nxt.cpu_en = 1'b1;
        end
      end
      default: begin
        s_nxt.mode = psave_pkg::ST_RUN;
        s_nxt.idle = 1'b0;
      end
    endcase
    s_nxt.low_power_rc_oscillator = watchdog_enable | fail_safe_monitor_enable;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{mode: psave_pkg::ST_RUN, cdiv: `CDIV_RESET, wclr: 1'b0,
               cpu_en: 1'b1, low_power_rc_oscillator: 1'b0, idle: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------
  // Sub-blocks
  // -----------------------------------------------------------
  doze_divider u_doze (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .doze_on (doze_on),
    .ratio   (ratio),
    .cpu_en  (doze_tick)
  );

  module_gate u_gate (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .md_bits    (module_clock_disable_bit),
    .en_bits    (module_function_enable_bit),
    .sidl_bits  (stop_in_idle_bit),
    .in_idle    (s_r.idle),
    .clk_en     (mod_clk_en),
    .run_en     (mod_run_en),
    .reg_access (mod_reg_access)
  );

  // Peripherals and system clock never slowed or stopped here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_clk_en <= 1'b1;
      sys_clk_run   <= 1'b1;
    end else begin
      periph_clk_en <= 1'b1;
      sys_clk_run   <= 1'b1;
    end
  end

  assign cpu_clk_en     = s_r.cpu_en;
  assign low_power_rc_oscillator_run       = s_r.low_power_rc_oscillator;
  assign watchdog_clear = s_r.wclr;
  assign in_idle        = s_r.idle;
  assign cdiv_rdata     = s_r.cdiv;

  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  a_idle_halts_cpu: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.mode == psave_pkg::ST_IDLE |-> !cpu_clk_en)
    else $error("CPU clock active in idle");
  a_entry_clears_wdt: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.mode == psave_pkg::ST_ENTER |=> watchdog_clear && in_idle)
    else $error("Idle entry did not clear watchdog");
  a_low_power_rc_oscillator_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (watchdog_enable || fail_safe_monitor_enable) |=> low_power_rc_oscillator_run)
    else $error("RC oscillator stopped while needed");
  a_wake_restores: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_r.mode == psave_pkg::ST_IDLE && (irq_s || wdt_s) |=> cpu_clk_en && !in_idle)
    else $error("Wake did not restore CPU clock");
  a_entry_defers_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(s_r.mode == psave_pkg::ST_ENTER) |=> in_idle)
    else $error("Entry aborted by interrupt");
  a_roi_ends_doze: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_s && s_r.cdiv[`CDIV_ROI_BIT] && !cdiv_we |=> !cdiv_rdata[`CDIV_SLOW_BIT])
    else $error("Return-on-interrupt ignored");
  a_no_roi_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_r.cdiv[`CDIV_ROI_BIT] && !cdiv_we |=> $stable(cdiv_rdata))
    else $error("Doze changed without write");
  a_md_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    module_clock_disable_bit[0] |=> !mod_clk_en[0] && !mod_reg_access[0] && !mod_run_en[0])
    else $error("Disabled module still clocked");
  a_sidl_halts: assert property (@(posedge ref_clk) disable iff (!rst_n)
    in_idle && stop_in_idle_bit[1] |=> !mod_run_en[1])
    else $error("Module ran in idle");
  c_idle_cycle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    power_save_instruction ##[1:5] in_idle ##[1:20] !in_idle);
  c_doze_run: cover property (@(posedge ref_clk) disable iff (!rst_n)
    doze_on && ratio == 3'h2 ##1 !cpu_clk_en);
  c_roi_exit: cover property (@(posedge ref_clk) disable iff (!rst_n)
    doze_on && irq_s && s_r.cdiv[`CDIV_ROI_BIT]);
endmodule // power_save_clock_gating

//--- sim/core_model.sv
`timescale 1ns/1ps
// ------------------------------
// CPU core stand-in
// ------------------------------
module core_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cpu_clk_en,
  output logic [15:0]      instr_cnt,
  output logic [8:0]       gap
);
  logic [8:0] since_r;
  // One instruction per enabled edge; gap is the last enable period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_cnt <= 16'h0000;
      since_r   <= 9'h000;
      gap       <= 9'h000;
    end else if (cpu_clk_en) begin
      instr_cnt <= instr_cnt + 16'h0001;
      gap       <= since_r + 9'h001;
      since_r   <= 9'h000;
    end else begin
      since_r <= since_r + 9'h001;
    end
  end
endmodule // core_model

//--- sim/power_save_clock_gating_test.sv
`timescale 1ns/1ps
`include "psave_consts.svh"
module power_save_clock_gating_test;
  logic ref_clk, rst_n, power_save_instruction, irq_pending, watchdog_timeout;
  logic watchdog_enable, fail_safe_monitor_enable, cdiv_we, cpu_clk_en, periph_clk_en;
  logic sys_clk_run, low_power_rc_oscillator_run, watchdog_clear, in_idle, saw;
  logic [15:0]          cdiv_wdata, cdiv_rdata, instr_cnt, snap;
  logic [8:0]           gap;
  logic [`NUM_MODS-1:0] module_clock_disable_bit, module_function_enable_bit;
  logic [`NUM_MODS-1:0] stop_in_idle_bit, mod_clk_en, mod_run_en, mod_reg_access;
  int                   err_count, samples_checked, cycles, i, k;

  power_save_clock_gating dut_u (.ref_clk, .rst_n, .power_save_instruction, .irq_pending,
    .watchdog_timeout, .watchdog_enable, .fail_safe_monitor_enable, .cdiv_we, .cdiv_wdata,
    .module_clock_disable_bit, .module_function_enable_bit, .stop_in_idle_bit, .cpu_clk_en,
    .periph_clk_en, .sys_clk_run, .low_power_rc_oscillator_run, .watchdog_clear, .in_idle, .cdiv_rdata,
    .mod_clk_en, .mod_run_en, .mod_reg_access);
  core_model core_u (.ref_clk, .rst_n, .cpu_clk_en, .instr_cnt, .gap);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ------------------------------
  // Access tasks
  // ------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("mismatches=%0d compares=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task cdiv_write(input logic [15:0] v);
    @(posedge ref_clk);
    cdiv_we    <= 1'b1;
    cdiv_wdata <= v;
    @(posedge ref_clk);
    cdiv_we <= 1'b0;
  endtask
  task enter_idle;
    @(posedge ref_clk);
    power_save_instruction <= 1'b1;
    @(posedge ref_clk);
    power_save_instruction <= 1'b0;
  endtask
  task wake;
    for (i = 0; i < 6 && in_idle !== 1'b0; i++) tick(1);
    chk({in_idle, cpu_clk_en}, 2'b01);
  endtask
  task chk_mods(input logic idle);
    // Braces keep the inversion at slot width, not at the task's width
    chk(mod_clk_en, {~module_clock_disable_bit});
    chk(mod_reg_access, {~module_clock_disable_bit});
    chk(mod_run_en, {~module_clock_disable_bit & (module_function_enable_bit | `MODS_NO_EN)
        & ~(stop_in_idle_bit & {`NUM_MODS{idle}})});
  endtask

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict;
    end
  end

  initial begin
    {rst_n, power_save_instruction, irq_pending, watchdog_timeout} = 4'h0;
    {watchdog_enable, fail_safe_monitor_enable, cdiv_we} = 3'h0;
    cdiv_wdata = 16'h0000;
    {module_clock_disable_bit, module_function_enable_bit, stop_in_idle_bit} = 24'h00_0000;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    chk({cpu_clk_en, periph_clk_en, sys_clk_run, in_idle}, 4'he);
    chk(cdiv_rdata, 16'h0000);
    @(posedge ref_clk) watchdog_enable <= 1'b1;
    enter_idle;
    tick(1);
    chk(cpu_clk_en, 1'b0);
    chk({in_idle, watchdog_clear, low_power_rc_oscillator_run, periph_clk_en, sys_clk_run}, 5'h1f);
    snap = instr_cnt;
    tick(1);
    chk(watchdog_clear, 1'b0);
    tick(10);
    chk(instr_cnt, snap);
    @(posedge ref_clk) irq_pending <= 1'b1;
    wake;
    @(posedge ref_clk) irq_pending <= 1'b0;
    tick(4);
    snap = instr_cnt;
    tick(4);
    chk(instr_cnt, snap + 16'h0004);
    enter_idle;
    tick(3);
    @(posedge ref_clk) watchdog_timeout <= 1'b1;
    wake;
    @(posedge ref_clk) watchdog_timeout <= 1'b0;
    enter_idle;
    tick(3);
    @(posedge ref_clk) rst_n <= 1'b0;
    tick(1);
    chk(in_idle, 1'b0);
    @(posedge ref_clk) rst_n <= 1'b1;
    // Interrupt in the entry cycle must not cancel the entry
    @(posedge ref_clk);
    irq_pending            <= 1'b1;
    power_save_instruction <= 1'b1;
    @(posedge ref_clk) power_save_instruction <= 1'b0;
    saw = 1'b0;
    for (i = 0; i < 10; i++) begin
      tick(1);
      if (in_idle === 1'b1) saw = 1'b1;
    end
    chk({saw, in_idle}, 2'b10);
    @(posedge ref_clk) irq_pending <= 1'b0;
    for (k = 0; k < 8; k++) begin
      cdiv_write({1'b0, k[2:0], 1'b1, 11'h000});
      tick(600);
      chk(cdiv_rdata, {1'b0, k[2:0], 1'b1, 11'h000});
      chk({7'h00, gap}, (k == 7) ? 16'h0100 : 16'h0001 << k);
      chk({periph_clk_en, sys_clk_run}, 2'b11);
    end
    cdiv_write(16'hb800);
    @(posedge ref_clk) irq_pending <= 1'b1;
    tick(6);
    chk(cdiv_rdata, 16'hb000);
    @(posedge ref_clk) irq_pending <= 1'b0;
    // Let the synchronised interrupt drain before return-on-interrupt is cleared
    tick(3);
    cdiv_write(16'h3800);
    @(posedge ref_clk) irq_pending <= 1'b1;
    tick(6);
    chk(cdiv_rdata, 16'h3800);
    @(posedge ref_clk) irq_pending <= 1'b0;
    cdiv_write(16'h0000);
    @(posedge ref_clk);
    module_clock_disable_bit   <= 8'h05;
    module_function_enable_bit <= 8'h12;
    stop_in_idle_bit           <= 8'hc3;
    watchdog_enable            <= 1'b0;
    fail_safe_monitor_enable   <= 1'b1;
    tick(2);
    chk_mods(1'b0);
    enter_idle;
    tick(4);
    chk(low_power_rc_oscillator_run, 1'b1);
    chk_mods(1'b1);
    @(posedge ref_clk) irq_pending <= 1'b1;
    wake;
    give_verdict;
  end
endmodule // power_save_clock_gating_test
